//--- hw/fsg_pkg.sv
// Constants and types shared by the flash security gate
package fsg_pkg;

  // ****************************************
  // Test access controller states
  // ****************************************
  typedef enum logic [3:0] {
    TAP_RESET    = 4'hf,
    TAP_IDLE     = 4'hc,
    TAP_SEL_DR   = 4'h7,
    TAP_CAP_DR   = 4'h6,
    TAP_SHIFT_DR = 4'h2,
    TAP_EXIT1_DR = 4'h1,
    TAP_PAUSE_DR = 4'h3,
    TAP_EXIT2_DR = 4'h0,
    TAP_UPD_DR   = 4'h5,
    TAP_SEL_IR   = 4'h4,
    TAP_CAP_IR   = 4'he,
    TAP_SHIFT_IR = 4'ha,
    TAP_EXIT1_IR = 4'h9,
    TAP_PAUSE_IR = 4'hb,
    TAP_EXIT2_IR = 4'h8,
    TAP_UPD_IR   = 4'hd
  } fsg_tap_state_t;

  // ****************************************
  // Erase sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ERS_IDLE = 2'h0,
    ERS_RUN  = 2'h1,
    ERS_DONE = 2'h2
  } fsg_ers_state_t;

  // ****************************************
  // Instruction register
  // ****************************************
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] INS_IDCODE = 4'h2;
  localparam logic [IR_W-1:0] INS_SAMPLE = 4'h3;
  localparam logic [IR_W-1:0] INS_DEBUG = 4'h7;
  localparam logic [IR_W-1:0] INS_LOCKOUT = 4'h8;
  localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;

  // ****************************************
  // Data registers and security word
  // ****************************************
  localparam int DIV_W = 7;
  localparam int ID_W = 32;
  localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_1001; // Arbitrary value
  localparam logic [1:0] SEC_SECURED = 2'h2;
  localparam int SEC_ADDR = 'h7ff7; // Flash word holding the security pattern

endpackage : fsg_pkg

//--- hw/fsg_tap_if.sv
// Carrier between the test access controller and the gate core
`timescale 1ns/1ns
`default_nettype none
interface fsg_tap_if;
  import fsg_pkg::*;
  fsg_tap_state_t state;
  logic tck_rise;
  logic tck_fall;
  modport ctrl (output state, output tck_rise, output tck_fall);
  modport user (input state, input tck_rise, input tck_fall);
endinterface : fsg_tap_if
`default_nettype wire

//--- hw/fsg_tap.sv
// Test access controller state machine, stepped on sampled test clock edges
`timescale 1ns/1ns
`default_nettype none
module fsg_tap
  import fsg_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Test pins
  input wire logic tck_i,
  input wire logic tms_i,
  // Towards the gate core
  fsg_tap_if.ctrl tap
);

  fsg_tap_state_t state_q, state_d;
  logic tck_q, tck_d;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    tck_d = tck_i;
    state_d = state_q;
    if (tck_i && !tck_q)
    begin
      case (state_q)
        TAP_RESET:    state_d = tms_i ? TAP_RESET : TAP_IDLE;
        TAP_IDLE:     state_d = tms_i ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR:   state_d = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR:   state_d = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: state_d = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: state_d = tms_i ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: state_d = tms_i ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: state_d = tms_i ? TAP_UPD_DR : TAP_SHIFT_DR;
        TAP_UPD_DR:   state_d = tms_i ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR:   state_d = tms_i ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR:   state_d = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: state_d = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: state_d = tms_i ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: state_d = tms_i ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: state_d = tms_i ? TAP_UPD_IR : TAP_SHIFT_IR;
        TAP_UPD_IR:   state_d = tms_i ? TAP_SEL_DR : TAP_IDLE;
        default:      state_d = TAP_RESET;
      endcase
    end
  end

  // ****************************************
  // Registers; device reset also resets the controller
  // ****************************************
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_q <= TAP_RESET;
      tck_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tck_q <= tck_d;
    end
  end

  assign tap.state = state_q;
  assign tap.tck_rise = tck_i && !tck_q;
  assign tap.tck_fall = !tck_i && tck_q;

endmodule : fsg_tap
`default_nettype wire

//--- hw/fsg_gate.sv
// Flash security gate on the debug path, with chip test port and lockout recovery erase
`timescale 1ns/1ns
`default_nettype none
module fsg_gate
  import fsg_pkg::*;
#(
  parameter int BSR_W = 8
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Test pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_n_o,
  // Nonvolatile security word
  input wire logic [1:0] sec_word_i,
  input wire logic sec_word_valid_i,
  // Debug emulation module
  input wire logic dbg_flash_req_i,
  output logic dbg_flash_gnt_o,
  output logic dbg_enable_o,
  output logic dbg_shift_o,
  output logic dbg_tdi_o,
  input wire logic dbg_tdo_i,
  // Boundary pins
  input wire logic [BSR_W-1:0] bsr_pins_i,
  // Flash mass erase
  output logic erase_run_o,
  output logic erase_tick_o,
  input wire logic erase_done_i,
  output logic secured_o
);

  if (BSR_W < 1)
  begin : g_bsr_check
    $error("BSR_W must be at least 1");
  end

  fsg_tap_if tap ();

  fsg_tap u_tap (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tck_i(tck_i),
    .tms_i(tms_i),
    .tap(tap)
  );

  // ****************************************
  // Security state
  // ****************************************
  logic secured_q, secured_d;
  logic loaded_q, loaded_d;

  // Secured from reset until the word is read, so nothing leaks in between
  always_comb
  begin
    secured_d = secured_q;
    loaded_d = loaded_q;
    if (!loaded_q && sec_word_valid_i)
    begin
      secured_d = (sec_word_i == SEC_SECURED);
      loaded_d = 1'b1;
    end
  end

  // Only a reset re-reads the word, so an erase never unlocks mid-session
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      secured_q <= 1'b1;
      loaded_q <= 1'b0;
    end
    else
    begin
      secured_q <= secured_d;
      loaded_q <= loaded_d;
    end
  end

  // Only debug paths are gated; the core sees no signal from here
  assign dbg_enable_o = !secured_q;
  assign dbg_flash_gnt_o = dbg_flash_req_i && !secured_q;
  assign secured_o = secured_q;

  // ****************************************
  // Instruction and data registers
  // ****************************************
  logic [IR_W-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
  logic [ID_W-1:0] id_sh_q, id_sh_d;
  logic [BSR_W-1:0] bsr_sh_q, bsr_sh_d;
  logic [DIV_W-1:0] div_sh_q, div_sh_d, div_q, div_d;
  logic byp_q, byp_d;
  logic tdo_q, tdo_d;
  logic oe_n_q, oe_n_d;
  logic dbg_sel;
  logic dr_out;

  assign dbg_sel = (ir_q == INS_DEBUG) && !secured_q;
  assign dbg_shift_o = dbg_sel && tap.state == TAP_SHIFT_DR && tap.tck_rise;
  assign dbg_tdi_o = tdi_i;

  // Serial output of the selected data register; a locked debug chain looks like bypass
  always_comb
  begin
    case (ir_q)
      INS_IDCODE:  dr_out = id_sh_q[0];
      INS_SAMPLE:  dr_out = bsr_sh_q[0];
      INS_LOCKOUT: dr_out = div_sh_q[0];
      INS_DEBUG:   dr_out = dbg_sel ? dbg_tdo_i : byp_q;
      default:     dr_out = byp_q;
    endcase
  end

  // Capture, shift and update on sampled test clock edges
  always_comb
  begin
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    id_sh_d = id_sh_q;
    bsr_sh_d = bsr_sh_q;
    div_sh_d = div_sh_q;
    div_d = div_q;
    byp_d = byp_q;
    tdo_d = tdo_q;
    oe_n_d = oe_n_q;
    if (tap.state == TAP_RESET)
      ir_d = INS_IDCODE;
    if (tap.tck_rise)
    begin
      case (tap.state)
        TAP_CAP_IR:   ir_sh_d = IR_CAPTURE;
        TAP_SHIFT_IR: ir_sh_d = {tdi_i, ir_sh_q[IR_W-1:1]};
        TAP_UPD_IR:   ir_d = ir_sh_q;
        TAP_CAP_DR:
        begin
          id_sh_d = ID_VALUE;
          bsr_sh_d = bsr_pins_i;
          div_sh_d = div_q;
          byp_d = 1'b0;
        end
        TAP_SHIFT_DR:
        begin
          case (ir_q)
            INS_IDCODE:  id_sh_d = {tdi_i, id_sh_q[ID_W-1:1]};
            INS_SAMPLE:  bsr_sh_d = {tdi_i, bsr_sh_q[BSR_W-1:1]};
            INS_LOCKOUT: div_sh_d = {tdi_i, div_sh_q[DIV_W-1:1]};
            default:     byp_d = tdi_i;
          endcase
        end
        TAP_UPD_DR:
        begin
          if (ir_q == INS_LOCKOUT)
            div_d = div_sh_q;
        end
        default:
        begin
        end
      endcase
    end
    // Output changes on the falling edge so the host samples a settled bit
    if (tap.tck_fall)
    begin
      oe_n_d = !(tap.state == TAP_SHIFT_DR || tap.state == TAP_SHIFT_IR);
      tdo_d = (tap.state == TAP_SHIFT_IR) ? ir_sh_q[0] : dr_out;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ir_sh_q <= IR_CAPTURE;
      ir_q <= INS_IDCODE;
      id_sh_q <= '0;
      bsr_sh_q <= '0;
      div_sh_q <= '0;
      div_q <= '0;
      byp_q <= 1'b0;
      tdo_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else
    begin
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
      id_sh_q <= id_sh_d;
      bsr_sh_q <= bsr_sh_d;
      div_sh_q <= div_sh_d;
      div_q <= div_d;
      byp_q <= byp_d;
      tdo_q <= tdo_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe_n_o = oe_n_q;

  // ****************************************
  // Lockout recovery erase sequencer
  // ****************************************
  fsg_ers_state_t ers_q, ers_d;
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  logic go;

  assign go = (ir_q == INS_LOCKOUT) && (tap.state == TAP_IDLE);

  // Leaving Run-Test/Idle early abandons the erase; the host must start over
  always_comb
  begin
    ers_d = ers_q;
    cnt_d = cnt_q;
    tick_d = 1'b0;
    case (ers_q)
      ERS_IDLE:
      begin
        cnt_d = div_q;
        if (go)
          ers_d = ERS_RUN;
      end
      ERS_RUN:
      begin
        if (!go)
          ers_d = ERS_IDLE;
        else if (erase_done_i)
          ers_d = ERS_DONE;
        else if (cnt_q == '0)
        begin
          cnt_d = div_q;
          tick_d = 1'b1;
        end
        else
          cnt_d = cnt_q - 1'b1;
      end
      ERS_DONE:   ers_d = ERS_DONE;
      default:    ers_d = ERS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      ers_q <= ERS_IDLE;
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      ers_q <= ers_d;
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign erase_run_o = (ers_q == ERS_RUN);
  assign erase_tick_o = tick_q;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_sec_load;
    !loaded_q && sec_word_valid_i && sec_word_i == SEC_SECURED;
  endsequence

  sequence s_erase_start;
    ers_q == ERS_IDLE && go;
  endsequence

  sec_decode_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_sec_load |=> secured_q [*3]) else $error("secured pattern not latched");
  open_decode_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !loaded_q && sec_word_valid_i && sec_word_i != SEC_SECURED |=> !secured_q)
    else $error("unsecured pattern left device locked");
  reset_block_a: assert property (@(posedge core_clk_i)
    $fell(rst_i) |-> secured_q && !dbg_flash_gnt_o) else $error("flash open after reset");
  grant_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    dbg_flash_gnt_o |-> !secured_q && dbg_flash_req_i) else $error("grant while secured");
  debug_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    secured_q |-> !dbg_enable_o && !dbg_shift_o) else $error("debug live while secured");
  erase_start_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_erase_start |=> erase_run_o) else $error("erase did not start");
  erase_cause_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(erase_run_o) |-> $past(go)) else $error("erase started without unlock");
  erase_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    erase_run_o && erase_done_i && go |=> !erase_run_o && secured_q == $past(secured_q))
    else $error("security changed at erase end");
  idle_abort_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    erase_run_o && !go |=> !erase_run_o) else $error("erase ran outside idle");
  tap_reset_a: assert property (@(posedge core_clk_i)
    rst_i |=> tap.state == TAP_RESET && ir_q == INS_IDCODE) else $error("reset missed controller");

endmodule : fsg_gate
`default_nettype wire

//--- test/fsg_jtag_host.sv
// Behavioural JTAG host that drives the test pins of the flash security gate
`timescale 1ns/1ns
`default_nettype none
module fsg_jtag_host
  import fsg_pkg::*;
(
  // Clock
  input wire logic core_clk_i,
  // Test pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_n_i
);
  logic last_q = 1'b0;
  logic seen;

  // A released tdo shows the inverse of its last level, so a stale bit never passes
  always @(posedge core_clk_i)
  begin
    if (tdo_oe_n_i === 1'b0)
      last_q <= tdo_i;
  end
  assign seen = (tdo_oe_n_i === 1'b0) ? tdo_i : ~last_q;

  // Test clock stands low between frames
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // One test clock period; a stopped clock keeps the controller where it is
  task automatic step(input logic m, input logic d, output logic o);
    tms_o = m;
    tdi_o = d;
    repeat (2) @(posedge core_clk_i);
    #1;
    o = seen;
    tck_o = 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    tck_o = 1'b0;
  endtask : step

  // Five high tms steps reach Test-Logic-Reset, then on to Run-Test/Idle
  task automatic reset_tap();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask : reset_tap

  // Shift n bits LSB first from Idle or Update, ending in Update
  task automatic shift(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir)
      step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
  endtask : shift
endmodule : fsg_jtag_host
`default_nettype wire

//--- test/tb_top.sv
// Self-checking testbench of the flash security gate
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  import fsg_pkg::*;
  localparam int BW = 8;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe_n, gnt, dbg_en, dbg_shift, dbg_tdi, run, tick, secured, b;
  logic sec_valid = 1'b0;
  logic req = 1'b0;
  logic dbg_tdo = 1'b0;
  logic done = 1'b0;
  logic [1:0] sec_word = 2'h0;
  logic [1:0] w;
  logic [6:0] div;
  logic [BW-1:0] bsr = '0;
  logic [31:0] seed = 32'h8079;
  logic [63:0] dout;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int nshift = 0;
  int n;

  // ***************
  // Clock, design and host
  // ***************
  always #50 core_clk_i = ~core_clk_i;

  fsg_gate #(.BSR_W(BW)) uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .sec_word_i(sec_word), .sec_word_valid_i(sec_valid),
    .dbg_flash_req_i(req), .dbg_flash_gnt_o(gnt), .dbg_enable_o(dbg_en), .dbg_shift_o(dbg_shift),
    .dbg_tdi_o(dbg_tdi), .dbg_tdo_i(dbg_tdo), .bsr_pins_i(bsr), .erase_run_o(run),
    .erase_tick_o(tick), .erase_done_i(done), .secured_o(secured));

  fsg_jtag_host host (.core_clk_i(core_clk_i), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
    .tdo_oe_n_i(tdo_oe_n));

  // ***************
  // Helpers
  // ***************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  // Only bit 1 set with bit 0 clear locks the part
  function automatic logic exp_sec(input logic [1:0] v);
    return v[1] & ~v[0];
  endfunction : exp_sec

  // A locked debug chain acts as bypass: a captured zero, then tdi one bit late
  function automatic logic [7:0] exp_chain(input logic [1:0] v, input logic [7:0] din, input logic chain);
    return exp_sec(v) ? {din[6:0], 1'b0} : {8{chain}};
  endfunction : exp_chain

  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // Hang guard well above the expected run of about 2500 cycles
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (dbg_shift === 1'b1)
      nshift++;
    if (cycles == 30000)
    begin
      fails++;
      end_sim();
    end
  end

  // Reset also returns the controller to Test-Logic-Reset, so step on to Idle
  task automatic do_reset();
    @(posedge core_clk_i) #1 rst_i = 1'b1;
    repeat (12) @(posedge core_clk_i);
    #1 rst_i = 1'b0;
    `CHK("secured after reset", 1'b1, secured)
    `CHK("tdo released", 1'b1, tdo_oe_n)
    host.step(1'b0, 1'b0, b);
  endtask : do_reset

  // Valid held a second cycle with another word, which must be ignored
  task automatic load_word(input logic [1:0] v);
    @(posedge core_clk_i) #1 sec_word = v;
    sec_valid = 1'b1;
    @(posedge core_clk_i) #1 sec_word = ~v;
    @(posedge core_clk_i) #1 sec_valid = 1'b0;
    `CHK("secured", exp_sec(v), secured)
  endtask : load_word

  // ***************
  // Scenarios
  // ***************
  initial
  begin
    do_reset();
    req = 1'b1;
    #1;
    `CHK("grant out of reset", 1'b0, gnt)
    `CHK("erase idle", 1'b0, run)
    // Every security pattern, then the locked one again to show that a reset after an open session locks again
    for (int i = 0; i < 5; i++)
    begin
      w = (i == 4) ? 2'h2 : i[1:0];
      do_reset();
      load_word(w);
      repeat (4)
      begin
        seed = xs(seed);
        @(posedge core_clk_i) #1 req = seed[0];
        #1;
        `CHK("grant", req & ~exp_sec(w), gnt)
        `CHK("debug enable", ~exp_sec(w), dbg_en)
      end
      host.shift(1'b1, IR_W, 64'(INS_IDCODE), dout);
      `CHK("ir capture", IR_CAPTURE, dout[IR_W-1:0])
      host.shift(1'b0, ID_W, 64'(seed), dout);
      `CHK("id code", ID_VALUE, dout[ID_W-1:0])
      bsr = seed[BW-1:0];
      host.shift(1'b1, IR_W, 64'(INS_SAMPLE), dout);
      host.shift(1'b0, BW, 64'(seed), dout);
      `CHK("boundary sample", bsr, dout[BW-1:0])
      dbg_tdo = seed[3];
      host.shift(1'b1, IR_W, 64'(INS_DEBUG), dout);
      nshift = 0;
      host.shift(1'b0, 8, 64'(seed), dout);
      `CHK("debug shifts", exp_sec(w) ? 0 : 8, nshift)
      `CHK("debug chain", exp_chain(w, seed[7:0], dbg_tdo), dout[7:0])
      `CHK("debug data in", tdi, dbg_tdi)
      host.step(1'b0, 1'b0, b);
    end
    // Recovery erase with the widest divider, then a random one
    for (int k = 0; k < 2; k++)
    begin
      seed = xs(seed);
      div = (k == 0) ? 7'h7f : seed[6:0];
      do_reset();
      load_word(2'h2);
      host.shift(1'b1, IR_W, 64'(INS_LOCKOUT), dout);
      host.shift(1'b0, DIV_W, 64'(div), dout);
      `CHK("erase before idle", 1'b0, run)
      host.step(1'b0, 1'b0, b);
      n = 0;
      while (run !== 1'b1 && n < 8)
      begin
        @(posedge core_clk_i) #1 n++;
      end
      `CHK("erase running", 1'b1, run)
      n = 0;
      while (tick !== 1'b1 && n < 300)
      begin
        @(posedge core_clk_i) #1 n++;
      end
      n = 0;
      do
      begin
        @(posedge core_clk_i) #1 n++;
      end
      while (tick !== 1'b1 && n < 300);
      `CHK("tick period", int'(div) + 1, n)
      // Second pass leaves Run-Test/Idle early, so the erase must be abandoned
      if (k == 1)
      begin
        host.step(1'b1, 1'b0, b);
        `CHK("erase abort", 1'b0, run)
      end
      @(posedge core_clk_i) #1 done = 1'b1;
      @(posedge core_clk_i) #1 done = 1'b0;
      #1;
      `CHK("erase finished", 1'b0, run)
      `CHK("secured until reset", 1'b1, secured)
      host.reset_tap();
    end
    // Erased word read after the next reset releases security
    do_reset();
    load_word(2'h0);
    `CHK("debug enable after erase", 1'b1, dbg_en)
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
